// ---- hw/cpmc_pkg.sv ----
// Purpose: shared constants and types of the clock prescale mode control
// Assumes: 50 MHz system clock
// Notes:   fetch and prescale counts are in system clocks, reset minimums in clk_i cycles
package cpmc_pkg;

    // clock source select codes
    typedef enum logic [1:0] {
        CPMC_SRC_CRYSTAL  = 2'h0,
        CPMC_SRC_EXTERNAL = 2'h1,
        CPMC_SRC_AUX_OSC  = 2'h2
    } cpmc_src_e;

    localparam int          CPMC_PRE_W          = 4;
    localparam int          CPMC_DIV_W          = 4;
    localparam int          CPMC_DOG_PRE_W      = 7;
    localparam int          CPMC_FETCH_W        = 2;
    localparam int          CPMC_RST_CNT_W      = 4;
    // divider: value n divides by n, value 0 treated as 1
    localparam logic [3:0]  CPMC_DIV_RST_COMPAT = 4'h2;
    localparam logic [3:0]  CPMC_DIV_RST_FAST   = 4'h1;
    localparam logic [3:0]  CPMC_PRE_RST_COMPAT = 4'h5;
    localparam logic [3:0]  CPMC_PRE_RST_FAST   = 4'h0;
    localparam logic [1:0]  CPMC_FETCH_COMPAT   = 2'h3;
    localparam logic [1:0]  CPMC_FETCH_FAST     = 2'h1;
    localparam logic [3:0]  CPMC_RST_MIN_COMPAT = 4'hC;
    localparam logic [3:0]  CPMC_RST_MIN_FAST   = 4'h2;

    // reset-time defaults chosen by the compatibility fuse
    function automatic logic [3:0] cpmc_pre_default(input logic compat);
        return compat ? CPMC_PRE_RST_COMPAT : CPMC_PRE_RST_FAST;
    endfunction : cpmc_pre_default

    function automatic logic [3:0] cpmc_div_default(input logic compat);
        return compat ? CPMC_DIV_RST_COMPAT : CPMC_DIV_RST_FAST;
    endfunction : cpmc_div_default

endpackage : cpmc_pkg

// ---- hw/cpmc_rst_filter.sv ----
// Purpose: qualify the synchronised external reset by minimum pulse length
// Assumes: rst_raw already synchronised to clk_i
// Notes:   counts up to the mode minimum, then holds core reset
`timescale 1ns/1ps
`default_nettype none
module cpmc_rst_filter
    import cpmc_pkg::*;
(
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   reset_i,
    // carrier
    cpmc_tick_if.filt   bus
);
    typedef struct packed {
        logic [CPMC_RST_CNT_W-1:0] cnt;
        logic                      hold;
    } cpmc_flt_s;

    cpmc_flt_s st;
    cpmc_flt_s next_st;
    logic [CPMC_RST_CNT_W-1:0] need;

    always_comb begin
        need    = bus.compat ? CPMC_RST_MIN_COMPAT : CPMC_RST_MIN_FAST;
        next_st = st;
        if (!bus.rst_raw) begin
            next_st.cnt  = '0;
            next_st.hold = 1'b0;
        end else if (st.cnt < need) begin
            next_st.cnt = st.cnt + 4'h1;
        end else begin
            next_st.hold = 1'b1; // see R19
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '{cnt: '0, hold: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign bus.rst_core = st.hold;

    // both mode minimums exceed one clock, so a single-clock pulse never qualifies
    a_short_pulse_ignored: assert property (@(posedge clk_i) disable iff (reset_i) // see R19
        $rose(bus.rst_raw) ##1 !bus.rst_raw |-> ##1 !st.hold)
        else $error("short reset pulse was accepted");
endmodule : cpmc_rst_filter
`default_nettype wire

// ---- hw/cpmc_tick_if.sv ----
// Purpose: carrier between reset filter and main control
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface cpmc_tick_if;
    logic       compat;
    logic       rst_raw;
    logic       rst_core;
    modport filt (input compat, input rst_raw, output rst_core);
    modport ctrl (output compat, output rst_raw, input rst_core);
endinterface : cpmc_tick_if
`default_nettype wire

// ---- hw/cpmc_top.sv ----
// Purpose: mode dependent clock, prescaler and pin sampling control
// Assumes: clk_i is the undivided oscillator; divider output is an enable
// Notes:   all outputs registered; pins pass a two-stage synchroniser
//
// Behaviour
// R1: compatibility mode divides oscillator by two
// R2: divider allows one or larger divisors
// R3: fast mode divider resets to one
// R4: system clock source selectable from three
// R5: reset polarity follows polarity pin level
// R6: power-on reset holds device in reset
// R7: one four-bit prescaler feeds timers and watchdog
// R8: compatibility prescale select resets to 0101
// R9: timer rate scales linearly, down to sixteenth
// R10: fast mode prescale select resets to zero
// R11: third timer bypasses prescaler in clockout/baud
// R12: pins sampled at prescaler or system rate
// R13: external reset held twelve or two clocks
// R14: fetch every three or every clock
// R15: watchdog bits placed by mode
// R16: watchdog has own seven-bit prescaler
// R17: fuse disabled selects fast mode
// R18: tick every select plus one clocks
// R19: reset synchronised and length qualified
`timescale 1ns/1ps
`default_nettype none
module cpmc_top
    import cpmc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // configuration
    input  wire logic        compat_fuse_i,
    input  wire logic        power_on_reset_i,
    input  wire logic [1:0]  clock_source_select_i,
    input  wire logic        double_speed_setting_i,
    input  wire logic [3:0]  clock_divisor_i,
    input  wire logic        clock_divisor_write_i,
    input  wire logic [3:0]  timer_prescale_select_i,
    input  wire logic        timer_prescale_write_i,
    input  wire logic        timer_two_bypass_i,
    input  wire logic        watchdog_idle_hold_i,
    input  wire logic        reset_output_disable_i,
    // pins
    input  wire logic        reset_pin_i,
    input  wire logic        reset_polarity_pin_i,
    input  wire logic        timer_zero_pin_i,
    input  wire logic        timer_one_pin_i,
    input  wire logic        timer_two_input_pin_i,
    input  wire logic        timer_two_capture_pin_i,
    input  wire logic        ext_irq_zero_pin_i,
    input  wire logic        ext_irq_one_pin_i,
    // status and timing outputs
    output logic             fast_mode_o,
    output logic [1:0]       clock_source_o,
    output logic             sys_clk_en_o,
    output logic [3:0]       timer_prescale_select_o,
    output logic             timer_tick_o,
    output logic             timer_two_tick_o,
    output logic             watchdog_tick_o,
    output logic             fetch_strobe_o,
    output logic [5:0]       sampled_pins_o,
    output logic             core_reset_o,
    output logic             reset_pull_up_o,
    output logic [1:0]       aux_ctrl_bits_o,
    output logic [1:0]       dog_ctrl_bits_o
);
    typedef struct packed {
        logic                      fuse_seen;
        logic                      compat;
        logic                      fast;
        logic [1:0]                src;
        logic [CPMC_DIV_W-1:0]     div;
        logic [CPMC_DIV_W-1:0]     div_cnt;
        logic [CPMC_PRE_W-1:0]     pre_sel;
        logic [CPMC_PRE_W-1:0]     pre_cnt;
        logic [CPMC_DOG_PRE_W-1:0] dog_pre;
        logic [CPMC_FETCH_W-1:0]   fetch_cnt;
        logic [7:0]                sync1;
        logic [7:0]                sync2;
        logic                      sys_en;
        logic                      tick;
        logic                      two_tick;
        logic                      dog_tick;
        logic                      fetch;
        logic [5:0]                sampled;
        logic                      core_rst;
        logic                      pull_up;
        logic [1:0]                aux_bits;
        logic [1:0]                dog_bits;
    } cpmc_top_s;

    cpmc_top_s   st;
    cpmc_top_s   next_st;
    cpmc_tick_if tif ();

    cpmc_rst_filter u_filter (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .bus     (tif.filt)
    );

    logic       rst_asserted;
    logic [3:0] eff_div;
    logic       div_wrap;
    logic       pre_wrap;

    always_comb begin
        // reset pin level meaning depends on polarity pin, both synchronised
        rst_asserted = st.sync2[7] ? st.sync2[6] : !st.sync2[6]; // see R5
        eff_div      = (st.div == 4'h0) ? 4'h1 : st.div;
        div_wrap     = (st.div_cnt >= eff_div - 4'h1);
        pre_wrap     = (st.pre_cnt >= st.pre_sel); // see R18
        next_st      = st;
        next_st.sync1 = {reset_polarity_pin_i, reset_pin_i, ext_irq_one_pin_i,
                         ext_irq_zero_pin_i, timer_two_capture_pin_i,
                         timer_two_input_pin_i, timer_one_pin_i, timer_zero_pin_i};
        next_st.sync2 = st.sync1;
        // fuse sampled once after reset release, never under async reset
        if (!st.fuse_seen) begin
            next_st.fuse_seen = 1'b1;
            next_st.compat    = compat_fuse_i; // see R17
            next_st.div       = cpmc_div_default(compat_fuse_i); // see R1 see R3
            next_st.pre_sel   = cpmc_pre_default(compat_fuse_i); // see R8 see R10
        end else begin
            if (clock_divisor_write_i) begin
                // double speed drops the default halving
                next_st.div = double_speed_setting_i ? 4'h1 : clock_divisor_i; // see R2
            end
            if (timer_prescale_write_i) begin
                next_st.pre_sel = timer_prescale_select_i; // see R7
            end
        end
        // kept as its own flop so the mode output needs no inverter after the register
        next_st.fast = !next_st.compat; // see R17
        next_st.src = (clock_source_select_i == 2'h3) ? 2'h0
                    : clock_source_select_i; // see R4
        // system clock enable from divider
        next_st.div_cnt = div_wrap ? 4'h0 : st.div_cnt + 4'h1;
        next_st.sys_en  = div_wrap;
        next_st.tick    = 1'b0;
        next_st.fetch   = 1'b0;
        next_st.dog_tick = 1'b0;
        next_st.two_tick = 1'b0;
        if (div_wrap) begin
            // shared prescaler, one tick per select plus one system clocks
            next_st.pre_cnt = pre_wrap ? 4'h0 : st.pre_cnt + 4'h1; // see R9
            next_st.tick    = pre_wrap; // see R7
            // third timer in clockout or baud runs at system rate
            next_st.two_tick = timer_two_bypass_i ? 1'b1 : pre_wrap; // see R11
            if (pre_wrap) begin
                next_st.dog_pre  = st.dog_pre + 7'h01;
                next_st.dog_tick = (st.dog_pre == 7'h7F); // see R16
            end
            if (st.fetch_cnt + 2'h1 >= (st.compat ? CPMC_FETCH_COMPAT : CPMC_FETCH_FAST)) begin
                next_st.fetch_cnt = 2'h0;
                next_st.fetch     = 1'b1; // see R14
            end else begin
                next_st.fetch_cnt = st.fetch_cnt + 2'h1;
            end
            if (!st.compat || pre_wrap) begin
                next_st.sampled = st.sync2[5:0]; // see R12
            end
        end
        next_st.pull_up  = !st.sync2[7]; // see R5
        // power-on source or qualified pin reset holds core
        next_st.core_rst = power_on_reset_i || tif.rst_core || !st.fuse_seen; // see R6 see R13
        next_st.aux_bits    = st.compat ? {watchdog_idle_hold_i, reset_output_disable_i}
                                        : 2'h0; // see R15
        next_st.dog_bits    = st.compat ? 2'h0
                                        : {watchdog_idle_hold_i, reset_output_disable_i};
    end

    assign tif.compat  = st.compat;
    assign tif.rst_raw = rst_asserted;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st          <= '0;
            st.compat   <= 1'b1;
            st.div      <= CPMC_DIV_RST_COMPAT;
            st.pre_sel  <= CPMC_PRE_RST_COMPAT;
            st.core_rst <= 1'b1;
            st.pull_up  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign fast_mode_o             = st.fast;
    assign clock_source_o          = st.src;
    assign sys_clk_en_o            = st.sys_en;
    assign timer_prescale_select_o = st.pre_sel;
    assign timer_tick_o            = st.tick;
    assign timer_two_tick_o        = st.two_tick;
    assign watchdog_tick_o         = st.dog_tick;
    assign fetch_strobe_o          = st.fetch;
    assign sampled_pins_o          = st.sampled;
    assign core_reset_o            = st.core_rst;
    assign reset_pull_up_o         = st.pull_up;
    assign aux_ctrl_bits_o         = st.aux_bits;
    assign dog_ctrl_bits_o         = st.dog_bits;

    // two quiet clocks after every compatibility mode fetch, whatever the divisor
    sequence s_fetch_gap_compat;
        !st.fetch ##1 !st.fetch;
    endsequence

    a_div_default: assert property (@(posedge clk_i) disable iff (reset_i) // see R1
        $rose(st.fuse_seen) |-> st.div == (st.compat ? CPMC_DIV_RST_COMPAT : CPMC_DIV_RST_FAST))
        else $error("divider default wrong for mode");
    a_div_double: assert property (@(posedge clk_i) disable iff (reset_i) // see R2
        st.fuse_seen && clock_divisor_write_i && double_speed_setting_i |=> st.div == 4'h1)
        else $error("double speed did not set divisor one");
    a_fast_div_one: assert property (@(posedge clk_i) disable iff (reset_i) // see R3
        $rose(st.fuse_seen) && !st.compat |-> st.div == CPMC_DIV_RST_FAST)
        else $error("fast mode divisor not one");
    a_src_legal: assert property (@(posedge clk_i) disable iff (reset_i) // see R4
        st.src != 2'h3)
        else $error("illegal clock source");
    a_pre_compat: assert property (@(posedge clk_i) disable iff (reset_i) // see R8
        $rose(st.fuse_seen) && st.compat |-> st.pre_sel == CPMC_PRE_RST_COMPAT)
        else $error("compat prescale default wrong");
    a_pre_fast: assert property (@(posedge clk_i) disable iff (reset_i) // see R10
        $rose(st.fuse_seen) && !st.compat |-> st.pre_sel == CPMC_PRE_RST_FAST)
        else $error("fast prescale default wrong");
    a_two_bypass: assert property (@(posedge clk_i) disable iff (reset_i) // see R11
        st.fuse_seen && div_wrap && timer_two_bypass_i |=> st.two_tick)
        else $error("third timer not bypassed");
    a_tick_spacing: assert property (@(posedge clk_i) disable iff (reset_i) // see R18
        st.tick && st.pre_sel != 4'h0 |=> !st.tick)
        else $error("prescaler ticks too close");
    a_fetch_compat: assert property (@(posedge clk_i) disable iff (reset_i) // see R14
        st.compat && st.fetch |=> s_fetch_gap_compat)
        else $error("compat fetch too fast");
    a_por_hold: assert property (@(posedge clk_i) disable iff (reset_i) // see R6
        power_on_reset_i |=> st.core_rst)
        else $error("power on reset not held");
    a_dog_place: assert property (@(posedge clk_i) disable iff (reset_i) // see R15
        st.compat |=> st.dog_bits == 2'h0 || !$past(st.compat))
        else $error("watchdog bits in wrong register");
endmodule : cpmc_top
`default_nettype wire

// ---- sim/cpmc_board_model.sv ----
// Purpose: board side reset source with its polarity strap
// Assumes: one press request starts one reset pulse
// Notes:   short_i commands a pulse below the mode minimum on purpose
`timescale 1ns/1ps
`default_nettype none
module cpmc_board_model (
    // bench control
    input  wire logic clk_i,
    input  wire logic polarity_i,
    input  wire logic compat_i,
    input  wire logic press_i,
    input  wire logic short_i,
    // pin
    output logic      reset_pin_o
);
    int   hold;
    logic asserted;
    initial hold = 0;
    always @(posedge clk_i) begin
        if (press_i && !short_i) begin
            hold <= compat_i ? 12 : 2;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
    end
    assign asserted    = press_i || (hold > 0);
    // idle level is the one the pull resistor gives for this strap
    assign reset_pin_o = polarity_i ? asserted : !asserted;
endmodule : cpmc_board_model
`default_nettype wire

// ---- sim/cpmc_top_tb_top.sv ----
// Purpose: self-checking bench of the clock prescale mode control
// Assumes: 50 MHz clock, inputs driven at the falling edge
// Notes:   periods are measured in clk_i cycles between pulses
`timescale 1ns/1ps
`default_nettype none
module cpmc_top_tb_top;
    import cpmc_pkg::*;
    typedef struct {logic [3:0] div; logic [3:0] pre; int sys; int tick;} cpmc_row_s;
    logic clk_i = 0, reset_i = 1, compat_fuse_i = 1, power_on_reset_i = 0;
    logic [1:0] clock_source_select_i = 2'h0;
    logic double_speed_setting_i = 0, clock_divisor_write_i = 0, timer_prescale_write_i = 0;
    logic [3:0] clock_divisor_i = 4'h0, timer_prescale_select_i = 4'h0;
    logic timer_two_bypass_i = 0, watchdog_idle_hold_i = 0, reset_output_disable_i = 0;
    logic reset_pin_i, reset_polarity_pin_i = 1, press = 0, short_p = 0;
    logic timer_zero_pin_i = 0, timer_one_pin_i = 0, timer_two_input_pin_i = 0;
    logic timer_two_capture_pin_i = 0, ext_irq_zero_pin_i = 0, ext_irq_one_pin_i = 0;
    logic fast_mode_o, sys_clk_en_o, timer_tick_o, timer_two_tick_o, watchdog_tick_o;
    logic fetch_strobe_o, core_reset_o, reset_pull_up_o;
    logic [1:0] clock_source_o, aux_ctrl_bits_o, dog_ctrl_bits_o;
    logic [3:0] timer_prescale_select_o;
    logic [5:0] sampled_pins_o;
    logic [4:0] mon;
    int errors = 0, samples_checked = 0, seen;
    cpmc_row_s rows [5] = '{'{4'h1, 4'h0, 1, 1}, '{4'h1, 4'hF, 1, 16}, '{4'h4, 4'h3, 4, 16},
                            '{4'h0, 4'h1, 1, 2}, '{4'h3, 4'h5, 3, 18}};
    assign mon = {watchdog_tick_o, timer_two_tick_o, fetch_strobe_o, timer_tick_o, sys_clk_en_o};
    always #10 clk_i = ~clk_i;
    cpmc_top uut (.clk_i, .reset_i, .compat_fuse_i, .power_on_reset_i, .clock_source_select_i,
        .double_speed_setting_i, .clock_divisor_i, .clock_divisor_write_i,
        .timer_prescale_select_i, .timer_prescale_write_i, .timer_two_bypass_i,
        .watchdog_idle_hold_i, .reset_output_disable_i, .reset_pin_i, .reset_polarity_pin_i,
        .timer_zero_pin_i, .timer_one_pin_i, .timer_two_input_pin_i, .timer_two_capture_pin_i,
        .ext_irq_zero_pin_i, .ext_irq_one_pin_i, .fast_mode_o, .clock_source_o, .sys_clk_en_o,
        .timer_prescale_select_o, .timer_tick_o, .timer_two_tick_o, .watchdog_tick_o,
        .fetch_strobe_o, .sampled_pins_o, .core_reset_o, .reset_pull_up_o, .aux_ctrl_bits_o,
        .dog_ctrl_bits_o);
    cpmc_board_model board (.clk_i(clk_i), .polarity_i(reset_polarity_pin_i),
        .compat_i(compat_fuse_i), .press_i(press), .short_i(short_p), .reset_pin_o(reset_pin_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic period(input int idx, input int exp, input string nm);
        int n;
        n = 0;
        while (mon[idx] !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        n = 1;
        while (mon[idx] !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        chk(n, exp, nm);
    endtask : period
    task automatic do_reset(input logic fuse);
        @(negedge clk_i);
        reset_i = 1;
        compat_fuse_i = fuse;
        repeat (8) @(negedge clk_i);
        reset_i = 0;
        repeat (4) @(negedge clk_i);
    endtask : do_reset
    task automatic wr(input logic [3:0] div, input logic [3:0] timer_prescale_select, input logic dbl);
        clock_divisor_i = div;
        timer_prescale_select_i = timer_prescale_select;
        double_speed_setting_i = dbl;
        clock_divisor_write_i = 1;
        timer_prescale_write_i = 1;
        @(negedge clk_i);
        clock_divisor_write_i = 0;
        timer_prescale_write_i = 0;
        double_speed_setting_i = 0;
        repeat (3) @(negedge clk_i);
    endtask : wr
    task automatic pin_reset(input logic shrt, input int rise_exp);
        short_p = shrt;
        press = 1;
        @(negedge clk_i);
        press = 0;
        seen = 0;
        repeat (25) begin
            @(negedge clk_i);
            if (core_reset_o === 1'b1) seen = 1;
        end
        chk(seen, rise_exp, "core_reset_o pin");
        repeat (6) @(negedge clk_i);
        chk(core_reset_o, 0, "core_reset_o release");
    endtask : pin_reset
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        // the whole run needs well under two thousand clocks
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        do_reset(0);
        chk(fast_mode_o, 1, "fast_mode_o");
        chk(timer_prescale_select_o, 4'h0, "prescale reset fast");
        period(0, 1, "sys period fast");
        period(2, 1, "fetch period fast");
        foreach (rows[i]) begin
            wr(rows[i].div, rows[i].pre, 0);
            chk(timer_prescale_select_o, rows[i].pre, "prescale select");
            period(0, rows[i].sys, "sys period");
            period(1, rows[i].tick, "tick period");
        end
        $display("table test done");
        wr(4'h1, 4'hF, 0);
        period(3, 16, "timer two tick no bypass");
        timer_two_bypass_i = 1;
        period(3, 1, "timer two tick bypass");
        timer_two_bypass_i = 0;
        wr(4'h1, 4'h0, 0);
        period(4, 128, "watchdog period");
        {ext_irq_one_pin_i, ext_irq_zero_pin_i, timer_two_capture_pin_i} = 3'h5;
        {timer_two_input_pin_i, timer_one_pin_i, timer_zero_pin_i} = 3'h6;
        repeat (6) @(negedge clk_i);
        chk(sampled_pins_o, 6'h2E, "pins fast");
        {watchdog_idle_hold_i, reset_output_disable_i} = 2'h2;
        repeat (3) @(negedge clk_i);
        chk({aux_ctrl_bits_o, dog_ctrl_bits_o}, 4'h2, "watchdog bits fast");
        chk(reset_pull_up_o, 0, "pull up pol high");
        pin_reset(1, 0);
        pin_reset(0, 1);
        power_on_reset_i = 1;
        @(negedge clk_i);
        chk(core_reset_o, 1, "core_reset_o por");
        power_on_reset_i = 0;
        repeat (4) @(negedge clk_i);
        $display("fast mode test done");
        reset_polarity_pin_i = 0;
        do_reset(1);
        chk(fast_mode_o, 0, "fast_mode_o");
        chk(timer_prescale_select_o, 4'h5, "prescale reset compat");
        chk(reset_pull_up_o, 1, "pull up pol low");
        period(0, 2, "sys period compat");
        period(1, 12, "tick period compat");
        period(2, 6, "fetch period compat");
        chk({aux_ctrl_bits_o, dog_ctrl_bits_o}, 4'h8, "watchdog bits compat");
        {watchdog_idle_hold_i, reset_output_disable_i} = 2'h1;
        repeat (3) @(negedge clk_i);
        chk({aux_ctrl_bits_o, dog_ctrl_bits_o}, 4'h4, "watchdog bits disable");
        {timer_two_input_pin_i, timer_one_pin_i, timer_zero_pin_i} = 3'h1;
        repeat (30) @(negedge clk_i);
        chk(sampled_pins_o, 6'h29, "pins compat");
        for (int s = 0; s < 4; s++) begin
            clock_source_select_i = s[1:0];
            repeat (3) @(negedge clk_i);
            chk(clock_source_o, (s == 3) ? 0 : s, "clock source");
        end
        pin_reset(1, 0);
        pin_reset(0, 1);
        wr(4'h4, 4'h5, 1);
        period(0, 1, "sys period double");
        $display("compat mode test done");
        end_of_test();
    end
endmodule : cpmc_top_tb_top
`default_nettype wire
